/* File: core/spcg_pkg.sv */
// Package: constants for the sensor clock generation block
package spcg_pkg;

  // ****************************************************************
  // Field widths
  // ****************************************************************
  localparam int PRE_W = 7;
  localparam int MULT_W = 8;
  localparam int DIV_W = 5;
  localparam int RS_W = 11;
  localparam int PER_W = 16;
  localparam int THR_W = 27;
  localparam int LINE_W = 16;
  localparam int LIM_W = 16;
  localparam int LOCK_W = 18;

  // ****************************************************************
  // Reset values (serial output defaults)
  // ****************************************************************
  localparam logic [PRE_W-1:0] PRE_RST = 7'h02;
  localparam logic [MULT_W-1:0] MULT_RST = 8'h40;
  localparam logic [DIV_W-1:0] CORE_DIV_RST = 5'h03;
  localparam logic [DIV_W-1:0] OUT_DIV_RST = 5'h0C;
  localparam logic [RS_W-1:0] RS_RST = 11'h101;
  localparam logic [LINE_W-1:0] LINE_RST = 16'h1000;

  // Fixed system dividers, not programmable
  localparam logic [1:0] CORE_SYS_DIV = 2'h1;
  localparam logic [1:0] OUT_SYS_DIV = 2'h1;

  // ****************************************************************
  // Field positions in the row-rate word
  // ****************************************************************
  localparam int RS_CORE_LSB = 0;
  localparam int RS_OUT_LSB = 8;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_PS = 4000;
  localparam longint LOCK_MAX_US = 1000;
  localparam longint LOCK_TYP_US = 200;
  localparam int LOCK_MAX_CYC = int'((LOCK_MAX_US * 1000000) / CLK_PERIOD_PS);
  localparam int LOCK_TYP_CYC = int'((LOCK_TYP_US * 1000000) / CLK_PERIOD_PS);

  // ****************************************************************
  // Parameter limits (frequencies in MHz)
  // ****************************************************************
  localparam logic [LIM_W-1:0] LIM_IP_MIN = 16'h0006;
  localparam logic [LIM_W-1:0] LIM_IP_MAX = 16'h0030;
  localparam logic [LIM_W-1:0] LIM_VCO_MIN = 16'h0180;
  localparam logic [LIM_W-1:0] LIM_VCO_MAX = 16'h0300;
  localparam logic [LIM_W-1:0] LIM_M_MIN = 16'h0020;
  localparam logic [LIM_W-1:0] LIM_M_MAX = 16'h0080;
  localparam logic [LIM_W-1:0] LIM_N_MIN = 16'h0001;
  localparam logic [LIM_W-1:0] LIM_N_MAX = 16'h0040;

  typedef enum logic [2:0] {
    SEL_IP_MIN = 3'h0,
    SEL_IP_MAX = 3'h1,
    SEL_VCO_MIN = 3'h2,
    SEL_VCO_MAX = 3'h3,
    SEL_M_MIN = 3'h4,
    SEL_M_MAX = 3'h5,
    SEL_N_MIN = 3'h6,
    SEL_N_MAX = 3'h7
  } spcg_lim_sel_t;

  typedef enum logic [1:0] {
    ST_STANDBY = 2'b00,
    ST_LOCK = 2'b01,
    ST_STREAM = 2'b10
  } spcg_state_t;

endpackage : spcg_pkg

/* File: core/spcg_rate_gen.sv */
// Rate generator: emits step/thresh ticks per system clock
`timescale 1ns/1ps
module spcg_rate_gen
  import spcg_pkg::*;
(
  // Clock and control
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  input wire logic run_i,
  // Rate
  input wire logic [MULT_W-1:0] step_i,
  input wire logic [THR_W-1:0] thresh_i,
  // Tick
  output logic tick_o
);

  logic [THR_W-1:0] acc_ff;
  logic [THR_W-1:0] nxt_acc;
  logic tick_ff;
  logic nxt_tick;
  logic [THR_W-1:0] sum;

  always_comb begin
    sum = acc_ff + THR_W'(step_i);
    nxt_acc = acc_ff;
    nxt_tick = 1'b0;
    if (!run_i || thresh_i == '0) begin
      nxt_acc = '0;
    end else if (sum >= thresh_i) begin
      // Ratio above one saturates at one tick per cycle
      nxt_acc = (sum - thresh_i >= thresh_i) ? '0 : sum - thresh_i;
      nxt_tick = 1'b1;
    end else begin
      nxt_acc = sum;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      acc_ff <= '0;
      tick_ff <= 1'b0;
    end else if (ce_i) begin
      acc_ff <= nxt_acc;
      tick_ff <= nxt_tick;
    end
  end

  assign tick_o = tick_ff;

  chk_rate_idle: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (ce_i && !run_i) |=> !tick_o) else $error("tick while rate generator stopped");

  chk_rate_thresh: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (ce_i && run_i && thresh_i != '0 && sum < thresh_i) |=> !tick_o)
    else $error("tick before threshold reached");

endmodule : spcg_rate_gen

/* File: core/spcg_top.sv */
// Sensor clock generation: prescaler, loop model, dividers, gating
`timescale 1ns/1ps
module spcg_top
  import spcg_pkg::*;
#(
  parameter int LOCK_CYC = LOCK_MAX_CYC
) (
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  // External input clock, sampled
  input wire logic external_input_clock_i,
  // Mode control
  input wire logic stream_req_i,
  // Divider programming
  input wire logic cfg_wr_i,
  input wire logic [PRE_W-1:0] cfg_prescale_i,
  input wire logic [MULT_W-1:0] cfg_mult_i,
  input wire logic [DIV_W-1:0] cfg_core_pixel_divider_i,
  input wire logic [DIV_W-1:0] cfg_output_pixel_divider_i,
  input wire logic [RS_W-1:0] cfg_row_rate_i,
  input wire logic [LINE_W-1:0] cfg_line_len_i,
  // Output FIFO
  input wire logic fifo_has_pixel_i,
  output logic fifo_pop_o,
  // Pixel clocks as enables
  output logic core_timing_pixel_clock_o,
  output logic output_pixel_clock_o,
  output logic line_start_o,
  // Domain gates and status
  output logic core_dom_en_o,
  output logic out_dom_en_o,
  output logic serial_dom_en_o,
  output logic loop_en_o,
  output logic loop_locked_o,
  output logic streaming_o,
  output logic [PER_W-1:0] meas_period_o,
  // Limit readback
  input wire logic [2:0] lim_sel_i,
  output logic [LIM_W-1:0] lim_value_o
);

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  logic [PRE_W-1:0] pre_ff, nxt_pre;
  logic [MULT_W-1:0] mult_ff, nxt_mult;
  logic [DIV_W-1:0] cdiv_ff, nxt_cdiv;
  logic [DIV_W-1:0] odiv_ff, nxt_odiv;
  logic [RS_W-1:0] rs_ff, nxt_rs;
  logic [LINE_W-1:0] line_len_ff, nxt_line_len;
  spcg_state_t state_ff, nxt_state;

  always_comb begin
    nxt_pre = pre_ff;
    nxt_mult = mult_ff;
    nxt_cdiv = cdiv_ff;
    nxt_odiv = odiv_ff;
    nxt_rs = rs_ff;
    nxt_line_len = line_len_ff;
    // Writes outside standby are dropped rather than corrupting live clocks
    if (cfg_wr_i && state_ff == ST_STANDBY) begin
      nxt_pre = cfg_prescale_i;
      nxt_mult = cfg_mult_i;
      nxt_cdiv = cfg_core_pixel_divider_i;
      nxt_odiv = cfg_output_pixel_divider_i;
      nxt_rs = cfg_row_rate_i;
      nxt_line_len = cfg_line_len_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      pre_ff <= PRE_RST;
      mult_ff <= MULT_RST;
      cdiv_ff <= CORE_DIV_RST;
      odiv_ff <= OUT_DIV_RST;
      rs_ff <= RS_RST;
      line_len_ff <= LINE_RST;
    end else if (ce_i) begin
      pre_ff <= nxt_pre;
      mult_ff <= nxt_mult;
      cdiv_ff <= nxt_cdiv;
      odiv_ff <= nxt_odiv;
      rs_ff <= nxt_rs;
      line_len_ff <= nxt_line_len;
    end
  end

  // ****************************************************************
  // Standby, lock, stream sequencing
  // ****************************************************************
  logic [LOCK_W-1:0] lock_cnt_ff, nxt_lock_cnt;
  logic lock_done;

  assign lock_done = (lock_cnt_ff == LOCK_W'(LOCK_CYC - 1));

  always_comb begin
    nxt_state = state_ff;
    nxt_lock_cnt = '0;
    case (state_ff)
      ST_STANDBY: begin
        if (stream_req_i) begin
          nxt_state = ST_LOCK;
        end
      end
      ST_LOCK: begin
        nxt_lock_cnt = lock_cnt_ff + LOCK_W'(1);
        if (!stream_req_i) begin
          nxt_state = ST_STANDBY;
        end else if (lock_done) begin
          nxt_state = ST_STREAM;
        end
      end
      ST_STREAM: begin
        if (!stream_req_i) begin
          nxt_state = ST_STANDBY;
        end
      end
      default: begin
        nxt_state = ST_STANDBY;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      state_ff <= ST_STANDBY;
      lock_cnt_ff <= '0;
    end else if (ce_i) begin
      state_ff <= nxt_state;
      lock_cnt_ff <= nxt_lock_cnt;
    end
  end

  assign loop_en_o = (state_ff != ST_STANDBY);
  assign streaming_o = (state_ff == ST_STREAM);
  assign core_dom_en_o = streaming_o;
  assign out_dom_en_o = streaming_o;
  assign serial_dom_en_o = 1'b1;

  // ****************************************************************
  // Prescaler and loop input period measurement
  // ****************************************************************
  logic ext_d_ff, nxt_ext_d;
  logic [PRE_W-1:0] pre_cnt_ff, nxt_pre_cnt;
  logic [PER_W-1:0] per_cnt_ff, nxt_per_cnt;
  logic [PER_W-1:0] period_ff, nxt_period;
  logic [PER_W-1:0] last_per_ff, nxt_last_per;
  logic locked_ff, nxt_locked;
  logic [PRE_W-1:0] pre_eff;
  logic pre_tick;

  assign pre_eff = (pre_ff == '0) ? PRE_W'(1) : pre_ff;
  assign pre_tick = loop_en_o && external_input_clock_i && !ext_d_ff
                    && (pre_cnt_ff == pre_eff - PRE_W'(1));

  always_comb begin
    nxt_ext_d = external_input_clock_i;
    nxt_pre_cnt = pre_cnt_ff;
    nxt_per_cnt = (per_cnt_ff == '1) ? per_cnt_ff : per_cnt_ff + PER_W'(1);
    nxt_period = period_ff;
    nxt_last_per = last_per_ff;
    nxt_locked = locked_ff && loop_en_o;
    if (!loop_en_o) begin
      nxt_pre_cnt = '0;
      nxt_per_cnt = '0;
      nxt_period = '0;
      nxt_last_per = '0;
    end else if (external_input_clock_i && !ext_d_ff) begin
      nxt_pre_cnt = pre_tick ? '0 : pre_cnt_ff + PRE_W'(1);
      if (pre_tick) begin
        nxt_per_cnt = PER_W'(1);
        nxt_period = per_cnt_ff;
        nxt_last_per = period_ff;
        // Two equal periods mark the loop as settled
        nxt_locked = (period_ff == per_cnt_ff) && (period_ff != '0);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      ext_d_ff <= 1'b0;
      pre_cnt_ff <= '0;
      per_cnt_ff <= '0;
      period_ff <= '0;
      last_per_ff <= '0;
      locked_ff <= 1'b0;
    end else if (ce_i) begin
      ext_d_ff <= nxt_ext_d;
      pre_cnt_ff <= nxt_pre_cnt;
      per_cnt_ff <= nxt_per_cnt;
      period_ff <= nxt_period;
      last_per_ff <= nxt_last_per;
      locked_ff <= nxt_locked;
    end
  end

  assign loop_locked_o = locked_ff;
  assign meas_period_o = period_ff;

  // ****************************************************************
  // Post dividers as rate generators
  // ****************************************************************
  logic [2:0] rs_core, rs_out;
  logic [THR_W-1:0] core_thr, out_thr;

  assign rs_core = (rs_ff[RS_CORE_LSB +: 3] == '0) ? 3'h1 : rs_ff[RS_CORE_LSB +: 3];
  assign rs_out = (rs_ff[RS_OUT_LSB +: 3] == '0) ? 3'h1 : rs_ff[RS_OUT_LSB +: 3];
  // Period already spans the prescaler, so it divides only by the post stages
  // Widen before multiplying so the product is not cut to the period width
  assign core_thr = THR_W'(period_ff) * THR_W'(cdiv_ff) * THR_W'(rs_core)
                    * THR_W'(CORE_SYS_DIV);
  assign out_thr = THR_W'(period_ff) * THR_W'(odiv_ff) * THR_W'(rs_out)
                   * THR_W'(OUT_SYS_DIV);

  spcg_rate_gen u_core_rate (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .ce_i(ce_i),
    .run_i(core_dom_en_o),
    .step_i(mult_ff),
    .thresh_i(core_thr),
    .tick_o(core_timing_pixel_clock_o)
  );

  spcg_rate_gen u_out_rate (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .ce_i(ce_i),
    .run_i(out_dom_en_o),
    .step_i(mult_ff),
    .thresh_i(out_thr),
    .tick_o(output_pixel_clock_o)
  );

  assign fifo_pop_o = output_pixel_clock_o && fifo_has_pixel_i;

  // ****************************************************************
  // Line period counted in core pixel periods
  // ****************************************************************
  logic [LINE_W-1:0] line_cnt_ff, nxt_line_cnt;
  logic line_start_ff, nxt_line_start;

  always_comb begin
    nxt_line_cnt = line_cnt_ff;
    nxt_line_start = 1'b0;
    if (!core_dom_en_o) begin
      nxt_line_cnt = '0;
    end else if (core_timing_pixel_clock_o) begin
      if (line_cnt_ff >= line_len_ff - LINE_W'(1)) begin
        nxt_line_cnt = '0;
        nxt_line_start = 1'b1;
      end else begin
        nxt_line_cnt = line_cnt_ff + LINE_W'(1);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      line_cnt_ff <= '0;
      line_start_ff <= 1'b0;
    end else if (ce_i) begin
      line_cnt_ff <= nxt_line_cnt;
      line_start_ff <= nxt_line_start;
    end
  end

  assign line_start_o = line_start_ff;

  // ****************************************************************
  // Read-only parameter limits
  // ****************************************************************
  logic [LIM_W-1:0] lim_ff, nxt_lim;

  always_comb begin
    case (spcg_lim_sel_t'(lim_sel_i))
      SEL_IP_MIN: nxt_lim = LIM_IP_MIN;
      SEL_IP_MAX: nxt_lim = LIM_IP_MAX;
      SEL_VCO_MIN: nxt_lim = LIM_VCO_MIN;
      SEL_VCO_MAX: nxt_lim = LIM_VCO_MAX;
      SEL_M_MIN: nxt_lim = LIM_M_MIN;
      SEL_M_MAX: nxt_lim = LIM_M_MAX;
      SEL_N_MIN: nxt_lim = LIM_N_MIN;
      default: nxt_lim = LIM_N_MAX;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      lim_ff <= '0;
    end else if (ce_i) begin
      lim_ff <= nxt_lim;
    end
  end

  assign lim_value_o = lim_ff;

  // ****************************************************************
  // Checks
  // ****************************************************************
  chk_lock_hold: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (state_ff == ST_LOCK) |-> !core_timing_pixel_clock_o && !output_pixel_clock_o)
    else $error("pixel clock running during lock");

  chk_lock_release: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (ce_i && state_ff == ST_LOCK && lock_done && stream_req_i) |=> streaming_o)
    else $error("stream not entered after lock delay");

  chk_lock_early: assert property (@(posedge clk_i) disable iff (!resetn_i)
    $rose(streaming_o) |-> $past(lock_cnt_ff) == LOCK_W'(LOCK_CYC - 1))
    else $error("stream entered before lock delay");

  chk_standby_gate: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (state_ff == ST_STANDBY) |-> !core_dom_en_o && !out_dom_en_o && serial_dom_en_o)
    else $error("domain clock active in standby");

  chk_wr_standby: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (ce_i && cfg_wr_i && state_ff == ST_STANDBY) |=> mult_ff == $past(cfg_mult_i))
    else $error("standby write not taken");

  chk_wr_stream: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (state_ff != ST_STANDBY) |=> $stable(mult_ff) && $stable(odiv_ff))
    else $error("divider changed outside standby");

  chk_rst_default: assert property (@(posedge clk_i)
    $past(!resetn_i) && resetn_i |-> mult_ff == MULT_RST && odiv_ff == OUT_DIV_RST)
    else $error("reset default wrong");

  chk_pre_count: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (ce_i && pre_tick) |=> pre_cnt_ff == '0 && per_cnt_ff == PER_W'(1))
    else $error("prescaler wrap wrong");

  chk_line_len: assert property (@(posedge clk_i) disable iff (!resetn_i)
    line_start_o |-> line_cnt_ff == '0 && $past(core_timing_pixel_clock_o))
    else $error("line start without pixel");

  chk_fifo_pop: assert property (@(posedge clk_i) disable iff (!resetn_i)
    fifo_pop_o |-> output_pixel_clock_o && out_dom_en_o)
    else $error("fifo unloaded off output clock");

  chk_limit_m: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (ce_i && lim_sel_i == 3'h4) |=> lim_value_o == LIM_M_MIN)
    else $error("limit readback wrong");

endmodule : spcg_top

/* File: tb/spcg_host_model.sv */
// Host model: external input clock, stream hold-off, FIFO feed
`timescale 1ns/1ps
module spcg_host_model #(
  parameter int EXT_HALF = 10,
  parameter int HOLD_CYC = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Bench commands
  input wire logic want_stream_i,
  input wire logic starve_i,
  // Toward the block
  output logic ext_clk_o,
  output logic stream_req_o,
  output logic fifo_has_pixel_o
);
  int half_cnt;
  int hold_cnt;

  always @(posedge clk_i) begin
    if (!resetn_i) begin
      half_cnt <= 0;
      hold_cnt <= 0;
      ext_clk_o <= 1'b0;
      stream_req_o <= 1'b0;
    end else begin
      // 12.5 MHz input: prescaled rate stays in band, as high as the tests allow
      if (half_cnt == EXT_HALF - 1) begin
        half_cnt <= 0;
        ext_clk_o <= !ext_clk_o;
      end else begin
        half_cnt <= half_cnt + 1;
      end
      // Scaled hold-off; dividers only change in standby, which ends one cycle after this rises
      if (!want_stream_i) begin
        hold_cnt <= 0;
        stream_req_o <= 1'b0;
      end else if (hold_cnt == HOLD_CYC) begin
        stream_req_o <= 1'b1;
      end else begin
        hold_cnt <= hold_cnt + 1;
      end
    end
  end

  assign fifo_has_pixel_o = !starve_i;
endmodule : spcg_host_model

/* File: tb/tb.sv */
// Self-checking bench for the sensor clock generation block
`timescale 1ns/1ps
module tb;
  import spcg_pkg::*;
  // ****************************************************************
  // Signals
  // ****************************************************************
  localparam int LOCK_T = 20;
  localparam int WIN = 1500;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic want_stream = 1'b0;
  logic starve = 1'b0;
  logic cfg_wr_i = 1'b0;
  logic [PRE_W-1:0] cfg_pre = 7'h02;
  logic [MULT_W-1:0] cfg_mult = 8'h40;
  logic [DIV_W-1:0] cfg_cdiv = 5'h03;
  logic [DIV_W-1:0] cfg_odiv = 5'h0C;
  logic [RS_W-1:0] cfg_rr = 11'h101;
  logic [LINE_W-1:0] cfg_line = 16'h1000;
  logic [2:0] lim_sel = 3'h0;
  logic ext_clk, stream_req, has_pix, pop, core_tk, out_tk, line_st;
  logic core_en, out_en, ser_en, loop_en, locked, streaming;
  logic [PER_W-1:0] meas;
  logic [LIM_W-1:0] lim_val;
  int errors = 0;
  int checked = 0;
  int n_core, n_out, n_line, n_pop, n_bad;

  always #2 clk_i = ~clk_i;

  spcg_host_model spcg_host_model_i (.clk_i(clk_i), .resetn_i(resetn_i),
    .want_stream_i(want_stream), .starve_i(starve), .ext_clk_o(ext_clk),
    .stream_req_o(stream_req), .fifo_has_pixel_o(has_pix));

  spcg_top #(.LOCK_CYC(LOCK_T)) spcg_top_i (.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(1'b1),
    .external_input_clock_i(ext_clk), .stream_req_i(stream_req), .cfg_wr_i(cfg_wr_i),
    .cfg_prescale_i(cfg_pre), .cfg_mult_i(cfg_mult), .cfg_core_pixel_divider_i(cfg_cdiv),
    .cfg_output_pixel_divider_i(cfg_odiv), .cfg_row_rate_i(cfg_rr),
    .cfg_line_len_i(cfg_line), .fifo_has_pixel_i(has_pix), .fifo_pop_o(pop),
    .core_timing_pixel_clock_o(core_tk), .output_pixel_clock_o(out_tk),
    .line_start_o(line_st), .core_dom_en_o(core_en), .out_dom_en_o(out_en),
    .serial_dom_en_o(ser_en), .loop_en_o(loop_en), .loop_locked_o(locked),
    .streaming_o(streaming), .meas_period_o(meas), .lim_sel_i(lim_sel),
    .lim_value_o(lim_val));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  // Rate counts carry a little phase slack at window edges
  function automatic logic [31:0] near(input int a, input int b);
    return 32'((a - b <= 2) && (b - a <= 2));
  endfunction : near

  task automatic step;
    @(posedge clk_i);
    #1;
  endtask : step

  task automatic count_window;
    n_core = 0;
    n_out = 0;
    n_line = 0;
    n_pop = 0;
    repeat (WIN) begin
      step();
      n_core += int'(core_tk);
      n_out += int'(out_tk);
      n_line += int'(line_st);
      n_pop += int'(pop);
    end
  endtask : count_window

  task automatic write_cfg(input logic [PRE_W-1:0] p, input logic [MULT_W-1:0] m,
                           input logic [DIV_W-1:0] cd, input logic [DIV_W-1:0] od,
                           input logic [RS_W-1:0] rr, input logic [LINE_W-1:0] ln);
    @(posedge clk_i);
    cfg_pre <= p;
    cfg_mult <= m;
    cfg_cdiv <= cd;
    cfg_odiv <= od;
    cfg_rr <= rr;
    cfg_line <= ln;
    cfg_wr_i <= 1'b1;
    @(posedge clk_i);
    cfg_wr_i <= 1'b0;
  endtask : write_cfg

  task automatic go_stream;
    int n;
    @(posedge clk_i);
    want_stream <= 1'b1;
    n = 0;
    while (loop_en !== 1'b1 && n < 100) begin
      step();
      n++;
    end
    n = 0;
    n_bad = 0;
    while (streaming !== 1'b1 && n < 1000) begin
      n_bad += int'(core_tk | out_tk | core_en | out_en | pop);
      step();
      n++;
    end
    check("lock_delay", 32'(n), 32'(LOCK_T));
    check("quiet_in_lock", 32'(n_bad), 32'h0);
    check("doms_on", {30'h0, core_en, out_en}, 32'h3);
    repeat (200) step();
  endtask : go_stream

  task automatic test_stop;
    @(posedge clk_i);
    want_stream <= 1'b0;
    repeat (3) step();
    check("standby", {29'h0, streaming, loop_en, ser_en}, 32'h1);
    count_window();
    check("gated_ticks", 32'(n_core + n_out + n_pop), 32'h0);
    check("doms_off", {30'h0, core_en, out_en}, 32'h0);
  endtask : test_stop

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic test_reset_limits;
    int lim_exp [8] = '{6, 48, 384, 768, 32, 128, 1, 64};
    check("idle", {28'h0, streaming, loop_en, core_en, ser_en}, 32'h1);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_i);
      lim_sel <= 3'(i);
      step();
      check("limit", 32'(lim_val), 32'(lim_exp[i]));
    end
  endtask : test_reset_limits

  // Defaults: n=2 m=64 cdiv 3 odiv 12, input 20 cycles a period
  task automatic test_default_rates;
    go_stream();
    count_window();
    check("core_rate", near(n_core, WIN * 64 / 120), 32'h1);
    check("out_rate", near(n_out, WIN * 64 / 480), 32'h1);
    check("quarter", near(n_out, n_core / 4), 32'h1);
    check("pops", 32'(n_pop), 32'(n_out));
    check("period", 32'(meas), 32'h28);
    check("locked", {31'h0, locked}, 32'h1);
    test_stop();
  endtask : test_default_rates

  // Parallel: n=1 m=32 cdiv 2 odiv 4, loop at 400 MHz
  task automatic test_parallel;
    write_cfg(7'h01, 8'h20, 5'h02, 5'h04, 11'h101, 16'h0010);
    go_stream();
    @(posedge clk_i);
    starve <= 1'b1;
    count_window();
    check("core_par", near(n_core, WIN * 32 / 40), 32'h1);
    check("out_par", near(n_out, WIN * 32 / 80), 32'h1);
    check("lines", near(n_line, WIN * 32 / 40 / 16), 32'h1);
    check("period_par", 32'(meas), 32'h14);
    check("locked_par", {31'h0, locked}, 32'h1);
    check("starved", 32'(n_pop), 32'h0);
    // Write while streaming must be dropped
    write_cfg(7'h02, 8'h40, 5'h03, 5'h0C, 11'h101, 16'h1000);
    @(posedge clk_i);
    starve <= 1'b0;
    count_window();
    check("kept_core", near(n_core, WIN * 32 / 40), 32'h1);
    check("kept_out", near(n_out, WIN * 32 / 80), 32'h1);
    test_stop();
  endtask : test_parallel

  // ****************************************************************
  // Run control
  // ****************************************************************
  task automatic wrap_up;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : wrap_up

  initial begin
    #100000;
    errors++;
    $display("BAD watchdog expected finish seen hang");
    wrap_up();
  end

  initial begin
    repeat (6) @(posedge clk_i);
    resetn_i <= 1'b1;
    step();
    test_reset_limits();
    test_default_rates();
    test_parallel();
    wrap_up();
  end
endmodule : tb
